// ===== src/sar_ctrl_cfg.svh
// Constants of the successive-approximation converter control block.
// Assumes a single 200 MHz system clock that oversamples the serial pins.
//
// Functional notes
// - Power-down is entered when a conversion finishes and whenever chip select is high.
// - Conversion finished with select low: analog section off, digital section stays active.
// - Digital section fully off only while chip select is high.
// - Comparator stays powered throughout a conversion, off only at power-down.
// - Each result bit appears on the serial output as soon as it is decided.
// - Raising chip select aborts any conversion at once and enters power-down.
// - Each serial clock cycle outputs the bit just decided and sets the trial for the next bit.
// - Select falling starts a conversion; first five serial clock periods sample the input.
// - After the fifth falling edge, drive a low bit, then 16 bits MSB first.
// - Serial output changes on each falling serial clock edge.
// - New conversion only after select goes high then low; extra clocks repeat the word LSB first, then do nothing.
`ifndef SAR_CTRL_CFG_SVH
`define SAR_CTRL_CFG_SVH

`define SAR_RESULT_BITS 16
`define SAR_BIT_IDX_BITS 4
`define SAR_SAMPLE_EDGES 3'h5
`define SAR_MSB_IDX 4'hf
`define SAR_LSB_IDX 4'h0
`define SAR_FIRST_REPEAT_IDX 4'h1
`define SAR_MSB_TRIAL 16'h8000
`define SAR_FIFO_DEPTH 4
`define SAR_SYNC_IDLE_HIGH 1'h1
`define SAR_SYNC_IDLE_LOW 1'h0

`endif

// ===== src/sar_ctrl_pkg.sv
// Types of the successive-approximation converter control block.
// Assumes sar_ctrl_cfg.svh is included before this package is compiled.
`include "sar_ctrl_cfg.svh"

package sar_ctrl_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SAMPLE,
    ST_CONVERT,
    ST_REPEAT,
    ST_FINISHED
  } conv_state_e;

  typedef logic [`SAR_RESULT_BITS-1:0] result_t;
  typedef logic [`SAR_BIT_IDX_BITS-1:0] bit_idx_t;

  typedef struct packed {
    logic cs_meta;
    logic cs_sync;
    logic cs_prev;
    logic sclk_meta;
    logic sclk_sync;
    logic sclk_prev;
    logic comp_meta;
    logic comp_sync;
    conv_state_e fsm;
    logic [2:0] smp_cnt;
    bit_idx_t bidx;
    logic last;
    result_t sar;
    result_t dac;
    logic dout;
    logic oe;
    logic pend_v;
    result_t pend_data;
  } ctrl_s;

endpackage

// ===== src/sar_result_fifo.sv
// Small synchronous FIFO that buffers finished conversion words.
// Assumes writer and reader share one clock and a synchronous active-low reset.
`timescale 1ns/1ps

module sar_result_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  // The storage sits in the state record, so one process owns every flop.
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [CW-1:0] count;
  } fifo_state_s;

  fifo_state_s st_r;
  fifo_state_s st_nxt;
  logic push;
  logic pop;

  assign in_ready_o = (st_r.count != CW'(DEPTH));
  assign out_valid_o = (st_r.count != '0);
  assign out_data_o = st_r.mem[st_r.rd_ptr];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.mem[st_r.wr_ptr] = in_data_i;
      st_nxt.wr_ptr = (st_r.wr_ptr == PW'(DEPTH - 1)) ? '0 : st_r.wr_ptr + 1'b1;
    end
    if (pop) begin
      st_nxt.rd_ptr = (st_r.rd_ptr == PW'(DEPTH - 1)) ? '0 : st_r.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      st_nxt.count = st_r.count + 1'b1;
    end else if (pop && !push) begin
      st_nxt.count = st_r.count - 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule // sar_result_fifo

// ===== src/sar_conv_ctrl.sv
// Control logic of a 16-bit successive-approximation converter serial port.
// Assumes the chip select, serial bit clock and comparator decision arrive
// asynchronously and are oversampled by the 200 MHz system clock.
`timescale 1ns/1ps
`include "sar_ctrl_cfg.svh"

module sar_conv_ctrl (
  input wire logic CLOCK_I,
  input wire logic RST_B_I,
  input wire logic CS_B_I,
  input wire logic SERIAL_BIT_CLOCK_I,
  input wire logic COMP_I,
  output logic DOUT_O,
  output logic DOUT_OE_O,
  output logic SAMPLE_O,
  output logic [`SAR_RESULT_BITS-1:0] DAC_CODE_O,
  output logic ANALOG_PWR_EN_O,
  output logic DIGITAL_PWR_EN_O,
  output logic POWER_DOWN_O,
  output logic [`SAR_RESULT_BITS-1:0] RESULT_DATA_O,
  output logic RESULT_VALID_O,
  input wire logic RESULT_READY_I
);

  sar_ctrl_pkg::ctrl_s st_r;
  sar_ctrl_pkg::ctrl_s st_nxt;
  logic fifo_in_ready;
  logic cs_high;
  logic cs_fall;
  logic sclk_fall;
  sar_ctrl_pkg::result_t sar_dec;

  // Chip select idles high and the other pins idle low, so the synchronisers
  // come out of reset showing the select released.
  localparam sar_ctrl_pkg::ctrl_s ST_RESET = '{
    cs_meta: `SAR_SYNC_IDLE_HIGH,
    cs_sync: `SAR_SYNC_IDLE_HIGH,
    cs_prev: `SAR_SYNC_IDLE_HIGH,
    sclk_meta: `SAR_SYNC_IDLE_LOW,
    sclk_sync: `SAR_SYNC_IDLE_LOW,
    sclk_prev: `SAR_SYNC_IDLE_LOW,
    comp_meta: `SAR_SYNC_IDLE_LOW,
    comp_sync: `SAR_SYNC_IDLE_LOW,
    fsm: sar_ctrl_pkg::ST_IDLE,
    smp_cnt: 3'h0,
    bidx: 4'h0,
    last: 1'h0,
    sar: 16'h0000,
    dac: 16'h0000,
    dout: 1'h0,
    oe: 1'h0,
    pend_v: 1'h0,
    pend_data: 16'h0000
  };

  // Edge detection reads only the second synchroniser stage and its copy.
  assign cs_high = st_r.cs_sync;
  assign cs_fall = st_r.cs_prev && !st_r.cs_sync;
  assign sclk_fall = st_r.sclk_prev && !st_r.sclk_sync;

  // Decided result word with the current comparator answer folded in.
  always_comb begin
    sar_dec = st_r.sar;
    sar_dec[st_r.bidx] = st_r.comp_sync;
  end

  always_comb begin
    st_nxt = st_r;

    st_nxt.cs_meta = CS_B_I;
    st_nxt.cs_sync = st_r.cs_meta;
    st_nxt.cs_prev = st_r.cs_sync;
    st_nxt.sclk_meta = SERIAL_BIT_CLOCK_I;
    st_nxt.sclk_sync = st_r.sclk_meta;
    st_nxt.sclk_prev = st_r.sclk_sync;
    st_nxt.comp_meta = COMP_I;
    st_nxt.comp_sync = st_r.comp_meta;

    // A finished word waits here until the FIFO takes it.
    if (st_r.pend_v && fifo_in_ready) begin
      st_nxt.pend_v = 1'b0;
    end

    if (cs_high) begin
      // Select high aborts whatever was running and releases the output.
      st_nxt.fsm = sar_ctrl_pkg::ST_IDLE;
      st_nxt.smp_cnt = 3'h0;
      st_nxt.bidx = `SAR_LSB_IDX;
      st_nxt.last = 1'b0;
      st_nxt.dac = '0;
      st_nxt.dout = 1'b0;
      st_nxt.oe = 1'b0;
    end else begin
      unique case (st_r.fsm)
        sar_ctrl_pkg::ST_IDLE: begin
          // Only a fresh falling select starts a frame; a select that was
          // already low when the block left reset counts as one, as the select synchronisers reset high.
          if (cs_fall) begin
            // A result still waiting for FIFO space blocks the start, so a
            // stalled reader never loses a word; the frame is then ignored.
            if (st_r.pend_v && !fifo_in_ready) begin
              st_nxt.fsm = sar_ctrl_pkg::ST_FINISHED;
            end else begin
              st_nxt.fsm = sar_ctrl_pkg::ST_SAMPLE;
              st_nxt.smp_cnt = 3'h0;
            end
          end
        end

        sar_ctrl_pkg::ST_SAMPLE: begin
          if (sclk_fall) begin
            if (st_r.smp_cnt == `SAR_SAMPLE_EDGES - 3'h1) begin
              // Fifth falling edge: sampling ends, the low lead bit goes out
              // and the MSB trial is put to the comparator.
              st_nxt.fsm = sar_ctrl_pkg::ST_CONVERT;
              st_nxt.oe = 1'b1;
              st_nxt.dout = 1'b0;
              st_nxt.bidx = `SAR_MSB_IDX;
              st_nxt.sar = '0;
              st_nxt.dac = `SAR_MSB_TRIAL;
            end else begin
              st_nxt.smp_cnt = st_r.smp_cnt + 3'h1;
            end
          end
        end

        sar_ctrl_pkg::ST_CONVERT: begin
          if (sclk_fall) begin
            // The bit just decided leaves at once while the next trial is set.
            st_nxt.sar = sar_dec;
            st_nxt.dout = st_r.comp_sync;
            if (st_r.bidx == `SAR_LSB_IDX) begin
              // Last decision: comparator off, word handed to the buffer.
              st_nxt.fsm = sar_ctrl_pkg::ST_REPEAT;
              st_nxt.dac = '0;
              st_nxt.bidx = `SAR_FIRST_REPEAT_IDX;
              st_nxt.last = 1'b0;
              st_nxt.pend_v = 1'b1;
              st_nxt.pend_data = sar_dec;
            end else begin
              st_nxt.bidx = st_r.bidx - 4'h1;
              st_nxt.dac = sar_dec | (`SAR_RESULT_BITS'(1) << (st_r.bidx - 4'h1));
            end
          end
        end

        sar_ctrl_pkg::ST_REPEAT: begin
          // The word is shifted out again LSB first, then the pin is released.
          if (sclk_fall) begin
            if (st_r.last) begin
              st_nxt.fsm = sar_ctrl_pkg::ST_FINISHED;
              st_nxt.oe = 1'b0;
              st_nxt.dout = 1'b0;
            end else begin
              st_nxt.dout = st_r.sar[st_r.bidx];
              st_nxt.last = (st_r.bidx == `SAR_MSB_IDX);
              st_nxt.bidx = st_r.bidx + 4'h1;
            end
          end
        end

        sar_ctrl_pkg::ST_FINISHED: begin
          // Further clocks with select low change nothing.
          st_nxt.fsm = sar_ctrl_pkg::ST_FINISHED;
        end

        default: begin
          st_nxt.fsm = sar_ctrl_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RST_B_I) begin
      st_r <= ST_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // The analog section, comparator included, runs only while sampling or
  // converting; every other state is the power-down state.
  assign ANALOG_PWR_EN_O = (st_r.fsm == sar_ctrl_pkg::ST_SAMPLE) ||
                           (st_r.fsm == sar_ctrl_pkg::ST_CONVERT);
  assign POWER_DOWN_O = !ANALOG_PWR_EN_O;
  // Digital logic keeps drawing power while select is low, even when idle,
  // which is why hosts should raise select between frames.
  assign DIGITAL_PWR_EN_O = !cs_high;
  assign SAMPLE_O = (st_r.fsm == sar_ctrl_pkg::ST_SAMPLE);
  assign DAC_CODE_O = st_r.dac;
  assign DOUT_O = st_r.dout;
  assign DOUT_OE_O = st_r.oe;

  sar_result_fifo #(
    .WIDTH(`SAR_RESULT_BITS),
    .DEPTH(`SAR_FIFO_DEPTH)
  ) u_result_fifo (
    .clk_i(CLOCK_I),
    .rst_b_i(RST_B_I),
    .in_data_i(st_r.pend_data),
    .in_valid_i(st_r.pend_v),
    .in_ready_o(fifo_in_ready),
    .out_data_o(RESULT_DATA_O),
    .out_valid_o(RESULT_VALID_O),
    .out_ready_i(RESULT_READY_I)
  );

endmodule // sar_conv_ctrl

// ===== test/sar_host_model.sv
// Host model: drives select, the serial bit clock and the comparator line.
// Assumes the 200 MHz system clock paces every pin change.
`timescale 1ns/1ps

module sar_host_model (
  input wire logic clk_i,
  input wire logic oe_i,
  input wire logic dout_i,
  output logic cs_b_o,
  output logic sclk_o,
  output logic comp_o
);
  // Six clocks a phase leave margin over the synchroniser and output register.
  localparam int HALF = 6;
  // One frame start every 2000 clocks keeps the throughput at 100 kHz.
  localparam int PERIOD = 2000;

  initial begin
    cs_b_o = 1'h1;
    sclk_o = 1'h0;
    comp_o = 1'h0;
  end

  task automatic frame(input logic [15:0] word, input int falls, output logic [15:0] got,
                       output logic lead, output logic seen);
    got = 16'h0;
    lead = 1'h1;
    seen = 1'h0;
    @(posedge clk_i) cs_b_o <= 1'h0;
    repeat (HALF) @(posedge clk_i);
    for (int i = 1; i <= falls; i++) begin
      sclk_o <= 1'h1;
      comp_o <= (i >= 6 && i <= 21) ? word[21-i] : ~comp_o;
      repeat (HALF) @(posedge clk_i);
      sclk_o <= 1'h0;
      repeat (HALF) @(posedge clk_i);
      seen = seen | oe_i;
      if (i == 5) lead = dout_i;
      if (i >= 6 && i <= 21) got[21-i] = dout_i;
    end
    cs_b_o <= 1'h1;
    repeat ((PERIOD - HALF * (2 * falls + 1) > 12) ? PERIOD - HALF * (2 * falls + 1) : 12)
      @(posedge clk_i);
  endtask
endmodule // sar_host_model

// ===== test/sar_conv_ctrl_props.sv
// Checker of the converter control ports: select, power and serial timing.
// Assumes it is bound to sar_conv_ctrl and clocked by the system clock.
`timescale 1ns/1ps
`include "sar_ctrl_cfg.svh"

module sar_conv_ctrl_props (
  input wire logic CLOCK_I,
  input wire logic RST_B_I,
  input wire logic CS_B_I,
  input wire logic SERIAL_BIT_CLOCK_I,
  input wire logic DOUT_O,
  input wire logic DOUT_OE_O,
  input wire logic SAMPLE_O,
  input wire logic [`SAR_RESULT_BITS-1:0] DAC_CODE_O,
  input wire logic ANALOG_PWR_EN_O,
  input wire logic DIGITAL_PWR_EN_O,
  input wire logic POWER_DOWN_O,
  input wire logic RESULT_VALID_O,
  input wire logic RESULT_READY_I
);
  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (!RST_B_I);
  // Six high samples cover the synchroniser and the output register after select rises; four low samples cover the synchroniser after it falls.
  sequence cs_high_run;
    CS_B_I [*6];
  endsequence
  sequence cs_low_run;
    !CS_B_I [*4];
  endsequence
  chk_oe_cs_off: assert property (cs_high_run |-> !DOUT_OE_O)
    else $error("serial output driven with select high");
  chk_dig_cs_off: assert property (cs_high_run |-> !DIGITAL_PWR_EN_O)
    else $error("digital section on with select high");
  chk_dig_cs_on: assert property (cs_low_run |-> DIGITAL_PWR_EN_O)
    else $error("digital section off with select low");
  chk_pd_cs_high: assert property (cs_high_run |-> POWER_DOWN_O && DAC_CODE_O == 16'h0)
    else $error("not powered down with select high");
  chk_pd_inverse: assert property (POWER_DOWN_O != ANALOG_PWR_EN_O)
    else $error("analog enable and power-down disagree");
  chk_comp_kept_on: assert property ($fell(ANALOG_PWR_EN_O) && !CS_B_I |-> $past(DAC_CODE_O[0]))
    else $error("analog section switched off before the last bit trial");
  chk_sample_pwr: assert property (SAMPLE_O |-> ANALOG_PWR_EN_O && !DOUT_OE_O)
    else $error("sampling without analog power or with output on");
  chk_dout_on_fall: assert property (DOUT_OE_O && $past(DOUT_OE_O) && $changed(DOUT_O)
    |-> !$past(SERIAL_BIT_CLOCK_I, 2))
    else $error("serial output changed outside a low clock phase");
  chk_oe_rise_low: assert property ($rose(DOUT_OE_O) |-> !DOUT_O && DAC_CODE_O == 16'h8000
    && !$past(SERIAL_BIT_CLOCK_I, 2))
    else $error("output enable rose without a low lead bit");
  chk_valid_hold: assert property (RESULT_VALID_O && !RESULT_READY_I |=> RESULT_VALID_O)
    else $error("result dropped before it was taken");
endmodule // sar_conv_ctrl_props

// ===== test/sar_adc_powerdown_shortcycle_tb_top.sv
// Testbench of the converter control block: frames, aborts and result buffering.
// Assumes the host model and the checker files are compiled before it.
`timescale 1ns/1ps

module sar_adc_powerdown_shortcycle_tb_top;
  logic clk, rst_b, ready, cs_b, sclk, comp, dout, oe, smp, apwr, dpwr, pd, rvalid;
  logic [15:0] dac, rdata, word, got, exp_q[$];
  logic lead, seen;
  logic [31:0] seed;
  int miscompares, comparisons, cycles;

  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end

  sar_host_model i_host (.clk_i(clk), .oe_i(oe), .dout_i(dout), .cs_b_o(cs_b),
    .sclk_o(sclk), .comp_o(comp));
  sar_conv_ctrl i_sar_conv_ctrl (.CLOCK_I(clk), .RST_B_I(rst_b), .CS_B_I(cs_b),
    .SERIAL_BIT_CLOCK_I(sclk), .COMP_I(comp), .DOUT_O(dout), .DOUT_OE_O(oe), .SAMPLE_O(smp),
    .DAC_CODE_O(dac), .ANALOG_PWR_EN_O(apwr), .DIGITAL_PWR_EN_O(dpwr), .POWER_DOWN_O(pd),
    .RESULT_DATA_O(rdata), .RESULT_VALID_O(rvalid), .RESULT_READY_I(ready));

  task automatic check(input logic [31:0] seen_v, input logic [31:0] exp_v);
    comparisons++;
    if (seen_v !== exp_v) begin
      miscompares++;
      $display("BAD t=%0t seen=%h expected=%h", $time, seen_v, exp_v);
    end
  endtask

  task automatic stop_test();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // The word is noted before the frame: with the reader ready it pops mid-frame.
  task automatic run(input int falls, input logic keep, input logic ok);
    logic [15:0] mask;
    word = 16'($random(seed));
    mask = ~(16'hffff >> ((falls > 21) ? 16 : falls - 5));
    if (keep) exp_q.push_back(word);
    i_host.frame(word, falls, got, lead, seen);
    check(seen, ok);
    if (ok) check({lead, got & mask}, {1'h0, word & mask});
    check({oe, pd, dpwr}, 3'h2);
  endtask

  always @(posedge clk) begin
    if (rst_b === 1'h1 && rvalid === 1'h1 && ready === 1'h1) begin
      if (exp_q.size() == 0) check(1'h1, 1'h0);
      else check(rdata, exp_q.pop_front());
    end
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      miscompares++;
      stop_test();
    end
  end

  initial begin
    seed = 32'hadec4bcb;
    rst_b = 1'h0;
    ready = 1'h1;
    repeat (4) @(posedge clk);
    rst_b <= 1'h1;
    repeat (8) @(posedge clk);
    run(40, 1'h1, 1'h1);
    $display("test full frame done");
    run(19, 1'h0, 1'h1);
    run(8, 1'h0, 1'h1);
    $display("test short cycle done");
    ready <= 1'h0;
    for (int k = 0; k < 5; k++) run(22, 1'h1, 1'h1);
    run(22, 1'h0, 1'h0);
    repeat (300) begin
      @(posedge clk);
      ready <= 1'($random(seed));
    end
    ready <= 1'h1;
    run(22, 1'h1, 1'h1);
    check(exp_q.size(), 0);
    $display("test buffering done");
    stop_test();
  end
endmodule // sar_adc_powerdown_shortcycle_tb_top

bind sar_conv_ctrl sar_conv_ctrl_props i_props (.CLOCK_I(CLOCK_I), .RST_B_I(RST_B_I),
  .CS_B_I(CS_B_I), .SERIAL_BIT_CLOCK_I(SERIAL_BIT_CLOCK_I), .DOUT_O(DOUT_O),
  .DOUT_OE_O(DOUT_OE_O), .SAMPLE_O(SAMPLE_O), .DAC_CODE_O(DAC_CODE_O),
  .ANALOG_PWR_EN_O(ANALOG_PWR_EN_O), .DIGITAL_PWR_EN_O(DIGITAL_PWR_EN_O),
  .POWER_DOWN_O(POWER_DOWN_O), .RESULT_VALID_O(RESULT_VALID_O),
  .RESULT_READY_I(RESULT_READY_I));
